// [core/zvs_gate_timing.sv]
/*
  Gate timing of a soft-switching flyback controller: zero-voltage pulse
  on the auxiliary gate, dead time, main gate on until current command.
  The shared pin carries one-wire serial configuration before brown-in.
  Assumes comparators for bulk level, soft-switch peak and current sense
  are outside; their outputs are asynchronous and synchronised here.
*/
// Overview of operation
// - Shared pin routes serial configuration until brown-in is seen.
// - After brown-in the serial path is off and pin weakly pulled down.
// - Brown-in and brown-out from bulk sense gate the start of switching.
// - Soft-switch pulse starts at period minus dead time minus pulse on-time.
// - Auxiliary pulse ends when negative current reaches the peak level.
// - Gap from auxiliary pulse end to main turn-on equals dead time.
// - Main gate turns on at the end of the dead time.
// - Soft-switch on-time scales with measured bulk voltage.
// - Main gate turns off when current sense reaches the command.
`timescale 1ns/1ps
module zvs_gate_timing #(
  parameter int unsigned CNT_W = zvs_pkg::CNT_W,
  parameter int unsigned ADC_W = zvs_pkg::ADC_W
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Configuration
  input  wire logic [CNT_W-1:0] period_i,
  input  wire logic [CNT_W-1:0] dead_i,
  input  wire logic [CNT_W-1:0] zvs_gain_i,
  input  wire logic             aux_pulse_mode_i,
  // Analog comparator and converter results
  input  wire logic             brown_in_i,
  input  wire logic             brown_out_i,
  input  wire logic [ADC_W-1:0] bulk_voltage_input_i,
  input  wire logic             soft_switch_peak_current_i,
  input  wire logic             cs_reached_i,
  // Shared pin
  input  wire logic             shared_pin_in_i,
  output logic                  shared_pin_out_o,
  output logic                  shared_pin_oe_o,
  output logic                  shared_pin_pulldown_o,
  // Serial configuration port, user side
  input  wire logic             uart_tx_i,
  input  wire logic             uart_tx_en_i,
  output logic                  uart_rx_o,
  output logic                  uart_active_o,
  // Gates
  output logic                  aux_gate_out_o,
  output logic                  main_gate_out_o
);
  localparam int unsigned FILT = (zvs_pkg::BROWN_FILT_CYC < 1) ? 1 :
                                 zvs_pkg::BROWN_FILT_CYC;

  zvs_pkg::phase_type phase_reg;
  zvs_pkg::phase_type phase_next;
  logic [CNT_W-1:0]   cyc_reg;
  logic [CNT_W-1:0]   dead_cnt_reg;
  logic [CNT_W-1:0]   zvs_on_reg;
  logic [CNT_W-1:0]   zvs_start;
  logic [CNT_W+ADC_W-1:0] prod;
  logic               run_reg;
  logic               bin_lvl;
  logic               bout_lvl;
  logic               pin_meta_reg;
  logic               pin_sync_reg;
  logic               pk_meta_reg;
  logic               pk_sync_reg;
  logic               cs_meta_reg;
  logic               cs_sync_reg;
  logic [ADC_W-1:0]   bulk_meta_reg;
  logic [ADC_W-1:0]   bulk_sync_reg;
  logic [ADC_W-1:0]   bulk_prev_reg;
  logic [ADC_W-1:0]   bulk_ok_reg;

  sync_filter #(.FILT(FILT)) u_bin (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (brown_in_i),
    .level_o (bin_lvl)
  );

  sync_filter #(.FILT(FILT)) u_bout (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (brown_out_i),
    .level_o (bout_lvl)
  );

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_reg  <= 1'b1;
      pin_sync_reg  <= 1'b1;
      pk_meta_reg   <= 1'b0;
      pk_sync_reg   <= 1'b0;
      cs_meta_reg   <= 1'b0;
      cs_sync_reg   <= 1'b0;
      bulk_meta_reg <= '0;
      bulk_sync_reg <= '0;
    end else begin
      pin_meta_reg  <= shared_pin_in_i;
      pin_sync_reg  <= pin_meta_reg;
      pk_meta_reg   <= soft_switch_peak_current_i;
      pk_sync_reg   <= pk_meta_reg;
      cs_meta_reg   <= cs_reached_i;
      cs_sync_reg   <= cs_meta_reg;
      bulk_meta_reg <= bulk_voltage_input_i;
      bulk_sync_reg <= bulk_meta_reg;
    end
  end

  // A converter word is used only once two samples agree, so a word
  // caught while its bits are changing never reaches the multiplier
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bulk_prev_reg <= '0;
      bulk_ok_reg   <= '0;
    end else begin
      bulk_prev_reg <= bulk_sync_reg;
      if (bulk_sync_reg == bulk_prev_reg) begin
        bulk_ok_reg <= bulk_sync_reg;
      end
    end
  end

  // Run once brown-in is seen; brown-out returns to configuration mode
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_reg <= 1'b0;
    end else if (bout_lvl) begin
      run_reg <= 1'b0;
    end else if (bin_lvl) begin
      run_reg <= 1'b1;
    end
  end

  // Shared pin: serial port before brown-in, weak pull-down after
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shared_pin_out_o      <= 1'b1;
      shared_pin_oe_o       <= 1'b0;
      shared_pin_pulldown_o <= 1'b0;
      uart_rx_o             <= 1'b1;
      uart_active_o         <= 1'b1;
    end else begin
      shared_pin_out_o      <= run_reg ? 1'b0 : uart_tx_i;
      shared_pin_oe_o       <= ~run_reg & uart_tx_en_i;
      shared_pin_pulldown_o <= run_reg;
      uart_rx_o             <= run_reg ? 1'b1 : pin_sync_reg;
      uart_active_o         <= ~run_reg;
    end
  end

  // On-time in proportion to bulk voltage, reloaded on every clock of the main phase
  assign prod = zvs_gain_i * bulk_ok_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zvs_on_reg <= '0;
    end else if (phase_reg == zvs_pkg::ST_MAIN) begin
      zvs_on_reg <= prod[zvs_pkg::SCALE_SHIFT +: CNT_W];
    end
  end

  // Saturate at zero so a short period does not wrap
  always_comb begin
    if ((CNT_W+1)'(dead_i) + (CNT_W+1)'(zvs_on_reg) >= (CNT_W+1)'(period_i))
      zvs_start = '0;
    else
      zvs_start = period_i - dead_i - zvs_on_reg;
  end

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      zvs_pkg::ST_CONFIG:
        if (run_reg) phase_next = zvs_pkg::ST_WAIT;
      zvs_pkg::ST_WAIT:
        if (cyc_reg >= zvs_start)
          phase_next = aux_pulse_mode_i ? zvs_pkg::ST_AUX
                                        : zvs_pkg::ST_DEAD;
      zvs_pkg::ST_AUX:
        if (pk_sync_reg) phase_next = zvs_pkg::ST_DEAD;
      zvs_pkg::ST_DEAD:
        if (dead_cnt_reg >= dead_i) phase_next = zvs_pkg::ST_MAIN;
      zvs_pkg::ST_MAIN:
        if (cs_sync_reg) phase_next = zvs_pkg::ST_OFF;
      zvs_pkg::ST_OFF:
        phase_next = zvs_pkg::ST_WAIT;
      default:
        phase_next = zvs_pkg::ST_CONFIG;
    endcase
    if (!run_reg) phase_next = zvs_pkg::ST_CONFIG;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) phase_reg <= zvs_pkg::ST_CONFIG;
    else         phase_reg <= phase_next;
  end

  // Counts cycles since main turn-on; the period equals period_i only
  // when the auxiliary pulse lasts exactly its planned on-time
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_reg <= '0;
    end else if (phase_next == zvs_pkg::ST_MAIN &&
                 phase_reg != zvs_pkg::ST_MAIN) begin
      cyc_reg <= (CNT_W)'(1);
    end else if (phase_reg == zvs_pkg::ST_CONFIG) begin
      cyc_reg <= '0;
    end else if (cyc_reg != '1) begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      dead_cnt_reg <= '0;
    else if (phase_reg == zvs_pkg::ST_DEAD)
      dead_cnt_reg <= dead_cnt_reg + 1'b1;
    else
      dead_cnt_reg <= (CNT_W)'(1);
  end

  // Gates come from the next phase so each is a single flop output
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_gate_out_o  <= 1'b0;
      main_gate_out_o <= 1'b0;
    end else begin
      aux_gate_out_o  <= (phase_next == zvs_pkg::ST_AUX);
      main_gate_out_o <= (phase_next == zvs_pkg::ST_MAIN);
    end
  end

  a_gates_exclusive: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    !(aux_gate_out_o && main_gate_out_o))
    else $error("Both gates active");

  a_config_quiet: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    uart_active_o |-> !aux_gate_out_o && !main_gate_out_o)
    else $error("Gate active in configuration mode");

  a_pin_pulldown: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(run_reg) |=> shared_pin_pulldown_o && !shared_pin_oe_o
      && !uart_active_o)
    else $error("Pin not pulled down after brown-in");

  a_aux_end: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    phase_reg == zvs_pkg::ST_AUX && pk_sync_reg && run_reg
      |=> !aux_gate_out_o)
    else $error("Aux pulse did not end at peak");

  a_main_off: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    phase_reg == zvs_pkg::ST_MAIN && cs_sync_reg |=> !main_gate_out_o)
    else $error("Main gate not off at current command");

  a_dead_gap: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    $fell(aux_gate_out_o) && run_reg && dead_i == 16'h0003
      && $stable(dead_i) |-> !main_gate_out_o [*3] ##1 main_gate_out_o)
    else $error("Dead time length wrong");

  a_brown_out: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    bout_lvl |=> ##1 phase_reg == zvs_pkg::ST_CONFIG)
    else $error("Switching continued after brown-out");

  a_uart_path: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    !run_reg |=> shared_pin_oe_o == $past(uart_tx_en_i))
    else $error("Serial path not routed before brown-in");
endmodule

// [core/zvs_pkg.sv]
/*
  Constants shared by the flyback gate-timing design.
  Assumes a 25 MHz single clock; all counts are in clock cycles.
*/
package zvs_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned ADC_W         = 10;
  localparam int unsigned SCALE_SHIFT   = 8;
  // Filter length for brown-in/brown-out comparator outputs
  localparam int unsigned BROWN_FILT_NS = 400;
  localparam int unsigned BROWN_FILT_CYC =
    (BROWN_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [15:0] PERIOD_RST    = 16'h00b2;
  localparam logic [15:0] DEAD_RST      = 16'h0005;
  localparam logic [15:0] ZVS_GAIN_RST  = 16'h0010;
  typedef enum logic [2:0] {
    ST_CONFIG = 3'b000,
    ST_WAIT   = 3'b001,
    ST_AUX    = 3'b010,
    ST_DEAD   = 3'b011,
    ST_MAIN   = 3'b100,
    ST_OFF    = 3'b101
  } phase_type;
endpackage

// [core/sync_filter.sv]
/*
  Two-flop synchroniser followed by a stable-count filter.
  Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
module sync_filter #(
  parameter int unsigned FILT = 10
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Data
  input  wire logic async_i,
  output logic      level_o
);
  logic       meta_reg;
  logic       sync_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  // A level must hold FILT cycles before it is believed
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 8'h00;
      level_o <= 1'b0;
    end else if (sync_reg == level_o) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg >= 8'(FILT - 1)) begin
      cnt_reg <= 8'h00;
      level_o <= sync_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// [verification/flyback_stage_model.sv]
/*
  Behavioural power stage: soft-switch peak and current-sense comparators.
  Assumes active-high gates; answers change at the falling clock edge.
*/
`timescale 1ns/1ps
module flyback_stage_model #(
  parameter int AUX_LEN  = 4,
  parameter int MAIN_LEN = 10
) (
  // Clock and gates
  input  wire logic clock_i,
  input  wire logic aux_gate_i,
  input  wire logic main_gate_i,
  // Comparator outputs
  output logic      peak_o,
  output logic      cs_o
);
  int a_cnt = 0;
  int m_cnt = 0;
  initial peak_o = 1'b0;
  initial cs_o = 1'b0;
  // Current only ramps while its gate is on, so a stuck gate shows up
  always @(negedge clock_i) begin
    a_cnt  <= aux_gate_i ? a_cnt + 1 : 0;
    m_cnt  <= main_gate_i ? m_cnt + 1 : 0;
    peak_o <= aux_gate_i && (a_cnt >= AUX_LEN);
    cs_o   <= main_gate_i && (m_cnt >= MAIN_LEN);
  end
endmodule

// [verification/test_zvs_gate_timing.sv]
/*
  Self-checking bench for the flyback gate-timing block.
  Assumes the stage model closes the loop and a host idles the shared pin.
*/
`timescale 1ns/1ps
module test_zvs_gate_timing;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [15:0] period_i = zvs_pkg::PERIOD_RST;
  logic [15:0] dead_i = zvs_pkg::DEAD_RST;
  logic [15:0] gain = zvs_pkg::ZVS_GAIN_RST;
  logic [9:0]  bulk = 10'h100;
  logic        mode = 1'b1;
  logic        b_in = 1'b0;
  logic        b_out = 1'b0;
  logic        tx = 1'b1;
  logic        tx_en = 1'b0;
  logic        host = 1'b1;
  logic        peak, cs, pin, p_out, p_oe, pull, rx, act, aux, main;
  logic        aux_q = 1'b0, main_q = 1'b0, peak_q = 1'b0, cs_q = 1'b0;
  int          bad_count = 0, checks_done = 0, cyc = 0;
  int          n_aux = 0, n_main = 0, aux_up, aux_dn, main_up, main_prev;
  int          main_dn, peak_t, cs_t;
  // Design drives the pin only while enabled; otherwise the host level
  assign pin = p_oe ? p_out : host;

  zvs_gate_timing zvs_gate_timing_i (.clock_i, .nrst_i, .period_i, .dead_i,
    .zvs_gain_i(gain), .aux_pulse_mode_i(mode), .brown_in_i(b_in),
    .brown_out_i(b_out), .bulk_voltage_input_i(bulk),
    .soft_switch_peak_current_i(peak), .cs_reached_i(cs),
    .shared_pin_in_i(pin), .shared_pin_out_o(p_out),
    .shared_pin_oe_o(p_oe), .shared_pin_pulldown_o(pull),
    .uart_tx_i(tx), .uart_tx_en_i(tx_en), .uart_rx_o(rx),
    .uart_active_o(act), .aux_gate_out_o(aux), .main_gate_out_o(main));
  flyback_stage_model flyback_stage_model_i (.clock_i, .aux_gate_i(aux),
    .main_gate_i(main), .peak_o(peak), .cs_o(cs));

  initial forever #20 clock_i = ~clock_i;

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Edge times in cycles, sampled just after each rising edge
  always @(posedge clock_i) begin
    #1;
    cyc++;
    if (aux === 1'b1 && main === 1'b1) chk("gate overlap", 0, 1);
    if (aux && !aux_q) n_aux++;
    if (aux && !aux_q) aux_up = cyc;
    if (!aux && aux_q) aux_dn = cyc;
    if (main && !main_q) main_prev = main_up;
    if (main && !main_q) main_up = cyc;
    if (main && !main_q) n_main++;
    if (!main && main_q) main_dn = cyc;
    if (peak && !peak_q) peak_t = cyc;
    if (cs && !cs_q) cs_t = cyc;
    {aux_q, main_q, peak_q, cs_q} = {aux, main, peak, cs};
  end

  task automatic wait_main(input int k);
    int s;
    s = n_main;
    repeat (k * 600) begin
      @(negedge clock_i);
      if (n_main >= s + k) return;
    end
    chk("main pulses", s + k, n_main);
  endtask

  task automatic gap(output int g);
    wait_main(3);
    g = aux_up - main_prev;
  endtask

  task automatic t_config;
    tx_en = 1'b1;
    tx = 1'b0;
    repeat (4) @(negedge clock_i);
    chk("pin enable", 1, p_oe);
    chk("pin drive", 0, p_out);
    chk("serial in", 0, rx);
    tx_en = 1'b0;
    repeat (4) @(negedge clock_i);
    chk("serial in", 1, rx);
    chk("config mode", 1, act);
    chk("gates", 0, {aux, main});
  endtask

  task automatic t_brown_in;
    int k;
    b_in = 1'b1;
    for (k = 0; k < 40 && act !== 1'b0; k++) @(negedge clock_i);
    chk("brown-in filtered", 1, k >= 10);
    chk("config mode", 0, act);
    @(negedge clock_i);
    tx_en = 1'b1;
    host = 1'b0;
    repeat (4) @(negedge clock_i);
    chk("pull-down", 1, pull);
    chk("pin enable", 0, p_oe);
    chk("serial in", 1, rx);
    tx_en = 1'b0;
  endtask

  task automatic t_cycle;
    int on;
    wait_main(2);
    repeat (40) @(negedge clock_i);
    on = (gain * bulk) >> zvs_pkg::SCALE_SHIFT;
    chk("dead time", dead_i, main_up - aux_dn);
    chk("aux end", 2, aux_dn - peak_t);
    chk("main end", 2, main_dn - cs_t);
    chk("zvs start", period_i - dead_i - on, aux_up - main_prev);
    chk("period", period_i - on + aux_dn - aux_up, main_up - main_prev);
  endtask

  task automatic t_start;
    int g0, g1;
    gap(g0);
    dead_i = 16'h0003;
    gap(g1);
    chk("start vs dead", g0 + 2, g1);
    dead_i = 16'h0005;
    period_i = 16'h00bc;
    gap(g1);
    chk("start vs period", g0 + 10, g1);
    period_i = 16'h00b2;
    bulk = 10'h200;
    gap(g1);
    chk("start vs bulk", g0 - 16, g1);
    bulk = 10'h100;
  endtask

  task automatic t_no_aux;
    int s;
    mode = 1'b0;
    wait_main(2);
    s = n_aux;
    wait_main(2);
    chk("aux pulses", s, n_aux);
    mode = 1'b1;
  endtask

  task automatic t_brown_out;
    int s;
    b_out = 1'b1;
    repeat (30) @(negedge clock_i);
    s = n_main + n_aux;
    repeat (400) @(negedge clock_i);
    chk("pulses after brown-out", s, n_main + n_aux);
    chk("gates", 0, {aux, main});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    t_config();
    t_brown_in();
    t_cycle();
    t_start();
    t_no_aux();
    t_cycle();
    t_brown_out();
    end_of_test();
  end

  // Run needs about 4000 cycles; five times that means a hang
  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule
